// ### core/sspr_strap_reset.sv
// Purpose: Strap capture, slot clock bits and fundamental reset handling
// Assumes: Straps are static around the release of fundamental reset
// Notes:   Register reads return data one cycle after the read strobe
//
// The implementer's own choices: the placing of the registers and the strobed register port.

// Overview of operation
// - Downstream strap seeds every downstream slot clock bit
// - Software rewrites each downstream slot clock bit
// - Upstream strap seeds upstream slot clock bit
// - Software rewrites upstream slot clock bit
// - Low reset pin resets all logic except the strap synchroniser, starts reset
// - Mode 0 normal, 1 EEPROM init, rest reserved
// - Port 0 is the upstream port
module sspr_strap_reset
  import sspr_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              fundamental_reset_n,
  input  wire logic              common_clock_downstream_strap,
  input  wire logic              common_clock_upstream_strap,
  input  wire logic [MODE_W-1:0] switch_mode_strap,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [DATA_W-1:0] regRdData,
  output logic      [NUM_PORTS-1:0] slotClockCfg,
  output logic      [MODE_W-1:0] switchMode,
  output logic                   eepromInitReq,
  output logic                   modeReserved,
  output logic                   fundResetActive,
  output logic                   configReady
);

  // ----------------------------------------------------------------
  // Reset and pin synchronisation
  // ----------------------------------------------------------------
  logic              coreRst;
  logic [MODE_W+1:0] strapSync;

  sspr_reset_gen u_reset_gen (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .fundamental_reset_n (fundamental_reset_n),
    .coreRst             (coreRst)
  );

  sspr_sync #(
    .WIDTH (MODE_W + 2)
  ) u_strap_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   ({switch_mode_strap, common_clock_upstream_strap, common_clock_downstream_strap}),
    .syncOut (strapSync)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 captured;
    logic [NUM_PORTS-1:0] sclk;
    logic [MODE_W-1:0]    mode;
    logic                 eeInit;
    logic                 rsvd;
    logic                 resetOut;
    logic [DATA_W-1:0]    rdData;
  } sspr_state_t;

  sspr_state_t state_r;
  sspr_state_t state_nxt;

  logic [NUM_PORTS-1:0] wrPort;
  logic                 dsStrap;
  logic                 usStrap;
  logic [MODE_W-1:0]    modeStrap;

  assign dsStrap   = strapSync[0];
  assign usStrap   = strapSync[1];
  assign modeStrap = strapSync[MODE_W+1:2];

  // ----------------------------------------------------------------
  // Per-port write decode
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_wr
      assign wrPort[gi] = regWrEn && (regAddr == ADDR_W'(gi * 4));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt          = state_r;
    state_nxt.resetOut = 1'b0;
    state_nxt.rdData   = RST_DATA;
    if (!state_r.captured) begin
      // First cycle out of reset: straps become initial state
      state_nxt.captured = 1'b1;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (p == UP_PORT) begin
          state_nxt.sclk[p] = usStrap;
        end else begin
          state_nxt.sclk[p] = dsStrap;
        end
      end
      state_nxt.mode = modeStrap;
      unique case (modeStrap)
        MODE_NORMAL: begin
          state_nxt.eeInit = 1'b0;
          state_nxt.rsvd   = 1'b0;
        end
        MODE_EEINIT: begin
          state_nxt.eeInit = 1'b1;
          state_nxt.rsvd   = 1'b0;
        end
        default: begin
          state_nxt.eeInit = 1'b0;
          state_nxt.rsvd   = 1'b1;
        end
      endcase
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wrPort[p]) begin
          state_nxt.sclk[p] = regWrData[SCLK_BIT];
        end
      end
    end
    if (regRdEn) begin
      if (regAddr == OFS_STATUS) begin
        state_nxt.rdData[ST_MODE_LSB +: MODE_W] = state_r.mode;
        state_nxt.rdData[ST_EEINIT_BIT]         = state_r.eeInit;
        state_nxt.rdData[ST_RSVD_BIT]           = state_r.rsvd;
        state_nxt.rdData[ST_READY_BIT]          = state_r.captured;
      end else begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (regAddr == ADDR_W'(p * 4)) begin
            state_nxt.rdData[SCLK_BIT] = state_r.sclk[p];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers: state cleared, resetOut set, while coreRst is high
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge coreRst) begin
    if (coreRst) begin
      state_r          <= '0;
      state_r.resetOut <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdData       = state_r.rdData;
  assign slotClockCfg    = state_r.sclk;
  assign switchMode      = state_r.mode;
  assign eepromInitReq   = state_r.eeInit;
  assign modeReserved    = state_r.rsvd;
  assign fundResetActive = state_r.resetOut;
  assign configReady     = state_r.captured;

endmodule : sspr_strap_reset

// ### core/sspr_pkg.sv
// Purpose: Shared constants and types for the strap and reset block
// Assumes: Four ports, port 0 upstream, 20 MHz system clock
// Notes:   Register map is a small local map on a plain port
package sspr_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS     = 4;
  localparam int unsigned UP_PORT       = 0;
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned MODE_W        = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_LSTS0  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_LSTS1  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_LSTS2  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SCLK_BIT      = 12;
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_EEINIT_BIT = 4;
  localparam int unsigned ST_RSVD_BIT   = 5;
  localparam int unsigned ST_READY_BIT  = 6;

  // ----------------------------------------------------------------
  // Mode encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_NORMAL = 3'h0;
  localparam logic [MODE_W-1:0] MODE_EEINIT = 3'h1;
  localparam logic [DATA_W-1:0] RST_DATA    = 32'h0;
  localparam logic              RST_BIT     = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SSPR_OP_NORMAL,
    SSPR_OP_EEINIT,
    SSPR_OP_RESERVED
  } sspr_op_t;

endpackage : sspr_pkg

// ### core/sspr_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are slow static levels
// Notes:   First stage is read only by the second stage
module sspr_sync
  import sspr_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sspr_sync_t;

  sspr_sync_t state_r;
  sspr_sync_t state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.meta   = pinIn;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign syncOut = state_r.stable;

endmodule : sspr_sync

// ### core/sspr_reset_gen.sv
// Purpose: Combine pin reset into an internal asynchronous reset
// Assumes: fundamental_reset_n is active low and asynchronous
// Notes:   Assertion is immediate, release is synchronised
module sspr_reset_gen
  import sspr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic fundamental_reset_n,
  output logic      coreRst
);

  typedef struct packed {
    logic meta;
    logic held;
  } sspr_rg_t;

  sspr_rg_t state_r;
  sspr_rg_t state_nxt;
  logic     anyRst;

  assign anyRst = rst | ~fundamental_reset_n;

  always_comb begin
    state_nxt      = state_r;
    state_nxt.meta = 1'b0;
    state_nxt.held = state_r.meta;
  end

  always_ff @(posedge sys_clk or posedge anyRst) begin
    if (anyRst) begin
      state_r <= '1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign coreRst = state_r.held;

endmodule : sspr_reset_gen

// ### dv/sspr_asserts.sv
// Purpose: Port-level checks of strap capture, slot clock bits and status
// Assumes: Straps stay steady once fundamental reset is released
// Notes:   Bound to the top module at the foot of this file
module sspr_asserts
  import sspr_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 fundamental_reset_n,
  input wire logic                 common_clock_downstream_strap,
  input wire logic                 common_clock_upstream_strap,
  input wire logic [MODE_W-1:0]    switch_mode_strap,
  input wire logic [ADDR_W-1:0]    regAddr,
  input wire logic [DATA_W-1:0]    regWrData,
  input wire logic                 regWrEn,
  input wire logic                 regRdEn,
  input wire logic [DATA_W-1:0]    regRdData,
  input wire logic [NUM_PORTS-1:0] slotClockCfg,
  input wire logic [MODE_W-1:0]    switchMode,
  input wire logic                 eepromInitReq,
  input wire logic                 modeReserved,
  input wire logic                 fundResetActive,
  input wire logic                 configReady
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_capture;
    $rose(configReady);
  endsequence
  sequence s_slot_wr;
    configReady && regWrEn && regAddr[1:0] == 2'h0 ##1 fundamental_reset_n;
  endsequence
  AST_SEED_DS: assert property (s_capture |-> slotClockCfg[3:1] == {3{common_clock_downstream_strap}})
    else $error("downstream slot bits differ from strap");
  AST_SEED_US: assert property (s_capture |-> slotClockCfg[0] == common_clock_upstream_strap)
    else $error("upstream slot bit differs from strap");
  AST_MODE_CAPT: assert property (s_capture |-> switchMode == switch_mode_strap)
    else $error("captured mode differs from strap");
  AST_MODE_DEC: assert property (configReady |-> eepromInitReq == (switchMode == MODE_EEINIT)
    && modeReserved == (switchMode > MODE_EEINIT))
    else $error("mode decode wrong");
  AST_PIN_RESET: assert property (!fundamental_reset_n |-> fundResetActive && !configReady && slotClockCfg == 4'h0)
    else $error("outputs not held in reset");
  AST_RELEASE: assert property ($rose(fundamental_reset_n) |-> ##[1:5] configReady)
    else $error("straps not captured after release");
  AST_SLOT_WR: assert property (s_slot_wr |-> slotClockCfg[$past(regAddr[3:2])] == $past(regWrData[SCLK_BIT]))
    else $error("slot bit write lost");
  AST_RD_STATUS: assert property (configReady && regRdEn && regAddr == OFS_STATUS |=>
    regRdData == {25'h0, 1'b1, $past(modeReserved), $past(eepromInitReq), 1'b0, $past(switchMode)})
    else $error("status read wrong");
endmodule : sspr_asserts

bind sspr_strap_reset sspr_asserts u_sspr_asserts (.sys_clk(sys_clk), .rst(rst),
  .fundamental_reset_n(fundamental_reset_n), .common_clock_downstream_strap(common_clock_downstream_strap),
  .common_clock_upstream_strap(common_clock_upstream_strap), .switch_mode_strap(switch_mode_strap),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .slotClockCfg(slotClockCfg), .switchMode(switchMode), .eepromInitReq(eepromInitReq),
  .modeReserved(modeReserved), .fundResetActive(fundResetActive), .configReady(configReady));

// ### dv/sspr_board.sv
// Purpose: Board straps and system reset controller
// Assumes: Bench asks for reset and strap levels
// Notes:   Mode strap is frozen once reset is released
module sspr_board
  import sspr_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              holdReset,
  input  wire logic              dsSet,
  input  wire logic              usSet,
  input  wire logic [MODE_W-1:0] modeSet,
  output logic                   fundamental_reset_n,
  output logic                   dsStrap,
  output logic                   usStrap,
  output logic      [MODE_W-1:0] modeStrap
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {fundamental_reset_n, dsStrap, usStrap, modeStrap} = '0;
  always @(posedge sys_clk) begin
    fundamental_reset_n <= !holdReset;
    dsStrap             <= dsSet;
    usStrap             <= usSet;
    if (holdReset) begin
      modeStrap <= modeSet;
    end
  end
endmodule : sspr_board

// ### dv/sspr_strap_reset_bench.sv
// Purpose: Self-checking bench of the strap and reset block
// Assumes: Board model drives straps and the reset pin
// Notes:   Each scenario is one task
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module sspr_strap_reset_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sspr_pkg::*;
  logic sys_clk = 0, rst = 1, holdReset = 1, dsSet = 0, usSet = 0, regWrEn = 0, regRdEn = 0;
  logic [MODE_W-1:0] modeSet = '0, swMode, mStrap;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData, d;
  logic [NUM_PORTS-1:0] slotClockCfg;
  logic fRstN, ds, us, eeReq, rsvd, fra, ready;
  int n_fail = 0, tests_run = 0;
  always #25 sys_clk = !sys_clk;
  sspr_board u_sspr_board (.sys_clk(sys_clk), .holdReset(holdReset), .dsSet(dsSet), .usSet(usSet),
    .modeSet(modeSet), .fundamental_reset_n(fRstN), .dsStrap(ds), .usStrap(us), .modeStrap(mStrap));
  sspr_strap_reset u_sspr_strap_reset (.sys_clk(sys_clk), .rst(rst), .fundamental_reset_n(fRstN),
    .common_clock_downstream_strap(ds), .common_clock_upstream_strap(us), .switch_mode_strap(mStrap),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .slotClockCfg(slotClockCfg), .switchMode(swMode), .eepromInitReq(eeReq), .modeReserved(rsvd),
    .fundResetActive(fra), .configReady(ready));
  task complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    regAddr <= a; regWrData <= v; regWrEn <= 1'b1;
    @(posedge sys_clk) regWrEn <= 1'b0;
    @(posedge sys_clk) #1;
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge sys_clk) regRdEn <= 1'b0;
    #1 v = regRdData;
    @(posedge sys_clk) #1;
  endtask : rd
  task boot(input logic dv, input logic uv, input logic [MODE_W-1:0] m);
    holdReset <= 1'b1; dsSet <= dv; usSet <= uv; modeSet <= m;
    repeat (5) @(posedge sys_clk);
    #1 `CHK({fra, ready, slotClockCfg}, 6'h20)
    holdReset <= 1'b0;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge sys_clk) #1;
    if (ready !== 1'b1) begin n_fail++; complete_run(); end
    `CHK(slotClockCfg, {dv, dv, dv, uv})
    `CHK({fra, swMode}, {1'b0, m})
    `CHK({eeReq, rsvd}, {m == MODE_EEINIT, m > MODE_EEINIT})
    rd(OFS_STATUS, d);
    `CHK(d, {25'h0, 1'b1, m > MODE_EEINIT, m == MODE_EEINIT, 1'b0, m})
  endtask : boot
  task override(input logic [NUM_PORTS-1:0] e);
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr(4'(p * 4), 32'(!e[p]) << SCLK_BIT);
      e[p] = !e[p];
      `CHK(slotClockCfg, e)
    end
    rd(OFS_LSTS1, d);
    `CHK(d[SCLK_BIT], e[1])
    wr(4'h2, 32'hffffffff);
    rd(4'h2, d);
    `CHK({d, slotClockCfg}, {32'h0, e})
    dsSet <= !dsSet;
    repeat (4) @(posedge sys_clk) #1;
    `CHK(slotClockCfg, e)
  endtask : override
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    boot(1'b1, 1'b0, MODE_NORMAL);
    override(4'he);
    for (int m = 0; m < 8; m++) boot(m[0], !m[0], 3'(m));
    complete_run();
  end
endmodule : sspr_strap_reset_bench
